//--- core/apm_regs.svh
`ifndef APM_REGS_SVH
`define APM_REGS_SVH
// Function
// - a new row needs a fresh chip-select fall or an upper address change.
// - random accesses with chip select low are spaced by the random cycle time.
// - host holds valid write data when chip select or write strobe rises.
// - host meets the access time before ending a write.
// - host gives every word write its own write strobe pulse.
// - page writes: more strobe pulses with new columns write the open row.
// - host holds chip select high for the precharge time between accesses.
// - host finishes accesses before sleep and waits the wake delay after it.

`define APM_ADDR_W         16
`define APM_DATA_W         16
`define APM_COL_W          2
`define APM_CNT_W          8
`define APM_CLK_NS         40
// timing figures, plain defaults, in ns
`define APM_ADDR_ACCESS_NS 100
`define APM_PAGE_ACCESS_NS 50
`define APM_PRECHARGE_NS   40
`define APM_RANDOM_CYC_NS  120
`define APM_WAKE_NS        1000
// least times round up to whole clock cycles
`define APM_ACC_CYC  ((`APM_ADDR_ACCESS_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_PAGE_CYC ((`APM_PAGE_ACCESS_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_PC_CYC   ((`APM_PRECHARGE_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_RC_CYC   ((`APM_RANDOM_CYC_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_WAKE_CYC ((`APM_WAKE_NS + `APM_CLK_NS - 1) / `APM_CLK_NS)
`define APM_BE_OFF   2'h3
`endif

//--- core/apm_pkg.sv
`include "apm_regs.svh"
package apm_pkg;
  typedef enum logic [2:0] {
    APM_IDLE, APM_SETUP, APM_ACC, APM_HOLD, APM_OPEN, APM_PRE, APM_SLEEP, APM_WAKE
  } apm_state_t;

  typedef struct packed {
    logic                    write;
    logic [`APM_ADDR_W-1:0]  addr;
    logic [`APM_DATA_W-1:0]  wdata;
    logic [1:0]              be_n;
  } apm_req_t;

  typedef struct packed {
    logic [`APM_ADDR_W-1:0]  addr;
    logic                    ce_n;
    logic                    we_n;
    logic                    oe_n;
    logic                    high_byte_sel_n;
    logic                    low_byte_sel_n;
    logic                    sleep_request_n;
    logic [`APM_DATA_W-1:0]  dq_out;
    logic                    dq_oe_n;
  } apm_pins_t;
endpackage

//--- core/apm_host.sv
`include "apm_regs.svh"
module apm_host
  import apm_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   req_valid,
  output      logic                   req_ready,
  input  wire apm_req_t               req,
  output      logic                   rsp_valid,
  output      logic [`APM_DATA_W-1:0] rsp_data,
  input  wire logic                   sleep_req,
  output      logic [`APM_ADDR_W-1:0] mem_addr,
  output      logic                   mem_ce_n,
  output      logic                   mem_we_n,
  output      logic                   mem_oe_n,
  output      logic                   high_byte_sel_n,
  output      logic                   low_byte_sel_n,
  output      logic                   sleep_request_n,
  output      logic [`APM_DATA_W-1:0] dq_out,
  output      logic                   dq_oe_n,
  input  wire logic [`APM_DATA_W-1:0] dq_in
);
  localparam apm_pins_t PINS_RST = '{
    addr: '0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, high_byte_sel_n: 1'b1,
    low_byte_sel_n: 1'b1, sleep_request_n: 1'b1, dq_out: '0, dq_oe_n: 1'b1};

  apm_state_t             st_ff,      nxt_st;
  apm_pins_t              pins_ff,    nxt_pins;
  apm_req_t               req_ff,     nxt_req;
  logic                   page_ff,    nxt_page;
  logic [`APM_CNT_W-1:0]  cnt_ff,     nxt_cnt;
  logic [`APM_CNT_W-1:0]  rc_ff,      nxt_rc;
  logic                   rsp_v_ff,   nxt_rsp_v;
  logic [`APM_DATA_W-1:0] rsp_d_ff,   nxt_rsp_d;
  logic                   same_row;
  logic                   take;

  // row is the address above the column bits
  assign same_row  = req.addr[`APM_ADDR_W-1:`APM_COL_W] ==
                     pins_ff.addr[`APM_ADDR_W-1:`APM_COL_W];
  assign req_ready = !sleep_req && ((st_ff == APM_IDLE) ||
                     (st_ff == APM_OPEN && same_row));
  assign take      = req_valid && req_ready;

  always_comb begin
    nxt_st    = st_ff;
    nxt_pins  = pins_ff;
    nxt_req   = req_ff;
    nxt_page  = page_ff;
    nxt_cnt   = cnt_ff;
    nxt_rc    = (rc_ff != '0) ? rc_ff - 1'b1 : rc_ff;
    nxt_rsp_v = 1'b0;
    nxt_rsp_d = rsp_d_ff;
    if (take) begin
      // address, byte selects and write data settle one cycle before strobes
      nxt_req                  = req;
      nxt_page                 = (st_ff == APM_OPEN);
      nxt_pins.addr            = req.addr;
      nxt_pins.high_byte_sel_n = req.be_n[1];
      nxt_pins.low_byte_sel_n  = req.be_n[0];
      nxt_pins.dq_out          = req.wdata;
      nxt_pins.dq_oe_n         = !req.write;
      nxt_st                   = APM_SETUP;
    end
    unique case (st_ff)
      APM_IDLE: begin
        if (sleep_req) begin
          nxt_pins.sleep_request_n = 1'b0;
          nxt_st                   = APM_SLEEP;
        end
      end
      APM_SETUP: begin
        nxt_pins.ce_n = 1'b0;
        nxt_pins.we_n = !req_ff.write;
        nxt_pins.oe_n = req_ff.write;
        if (page_ff) begin
          nxt_cnt = `APM_CNT_W'(`APM_PAGE_CYC - 1);
        end else begin
          nxt_cnt = `APM_CNT_W'(`APM_ACC_CYC - 1);
          nxt_rc  = `APM_CNT_W'(`APM_RC_CYC - 1);
        end
        nxt_st = APM_ACC;
      end
      APM_ACC: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else if (req_ff.write) begin
          nxt_pins.we_n = 1'b1;
          nxt_st        = APM_HOLD;
        end else begin
          nxt_rsp_v     = 1'b1;
          nxt_rsp_d     = dq_in;
          nxt_pins.oe_n = 1'b1;
          nxt_st        = APM_OPEN;
        end
      end
      APM_HOLD: begin
        nxt_pins.dq_oe_n = 1'b1;
        nxt_st           = APM_OPEN;
      end
      APM_OPEN: begin
        if (!take) begin
          // other row, sleep or nothing to do: close the row by precharge
          nxt_pins.ce_n = 1'b1;
          nxt_cnt       = `APM_CNT_W'(`APM_PC_CYC - 1);
          nxt_st        = APM_PRE;
        end
      end
      APM_PRE: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else if (rc_ff == '0) begin
          nxt_st = APM_IDLE;
        end
      end
      APM_SLEEP: begin
        if (!sleep_req) begin
          nxt_pins.sleep_request_n = 1'b1;
          nxt_cnt                  = `APM_CNT_W'(`APM_WAKE_CYC - 1);
          nxt_st                   = APM_WAKE;
        end
      end
      APM_WAKE: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else begin
          nxt_st = APM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff    <= APM_IDLE;
      pins_ff  <= PINS_RST;
      req_ff   <= '0;
      page_ff  <= 1'b0;
      cnt_ff   <= '0;
      rc_ff    <= '0;
      rsp_v_ff <= 1'b0;
      rsp_d_ff <= '0;
    end else begin
      st_ff    <= nxt_st;
      pins_ff  <= nxt_pins;
      req_ff   <= nxt_req;
      page_ff  <= nxt_page;
      cnt_ff   <= nxt_cnt;
      rc_ff    <= nxt_rc;
      rsp_v_ff <= nxt_rsp_v;
      rsp_d_ff <= nxt_rsp_d;
    end
  end

  assign rsp_valid       = rsp_v_ff;
  assign rsp_data        = rsp_d_ff;
  assign mem_addr        = pins_ff.addr;
  assign mem_ce_n        = pins_ff.ce_n;
  assign mem_we_n        = pins_ff.we_n;
  assign mem_oe_n        = pins_ff.oe_n;
  assign high_byte_sel_n = pins_ff.high_byte_sel_n;
  assign low_byte_sel_n  = pins_ff.low_byte_sel_n;
  assign sleep_request_n = pins_ff.sleep_request_n;
  assign dq_out          = pins_ff.dq_out;
  assign dq_oe_n         = pins_ff.dq_oe_n;

  // helper counters read only by the checks below
  int ce_hi_cnt;
  int we_lo_cnt;
  int ce_lo_cnt;
  int awake_cnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_hi_cnt <= 0;
      we_lo_cnt <= 0;
      ce_lo_cnt <= 0;
      // the memory counts as long awake out of reset
      awake_cnt <= 255;
    end else begin
      ce_hi_cnt <= mem_ce_n ? ((ce_hi_cnt < 255) ? ce_hi_cnt + 1 : ce_hi_cnt) : 0;
      we_lo_cnt <= !mem_we_n ? ((we_lo_cnt < 255) ? we_lo_cnt + 1 : we_lo_cnt) : 0;
      ce_lo_cnt <= !mem_ce_n ? ((ce_lo_cnt < 255) ? ce_lo_cnt + 1 : ce_lo_cnt) : 0;
      awake_cnt <= sleep_request_n ?
                   ((awake_cnt < 255) ? awake_cnt + 1 : awake_cnt) : 0;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_end;
    $rose(mem_we_n) && !mem_ce_n;
  endsequence

  property p_precharge;
    $fell(mem_ce_n) |-> ce_hi_cnt >= `APM_PC_CYC;
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge too short");

  property p_write_len;
    s_write_end |-> we_lo_cnt >= `APM_PAGE_CYC;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write ended early");

  property p_write_len_rand;
    $rose(mem_we_n) && !mem_ce_n && !page_ff |-> we_lo_cnt >= `APM_ACC_CYC;
  endproperty
  a_write_len_rand: assert property (p_write_len_rand) else $error("random write ended early");

  property p_write_data;
    s_write_end |-> !dq_oe_n ##1 dq_oe_n;
  endproperty
  a_write_data: assert property (p_write_data) else $error("write data not held");

  property p_we_pulse;
    $rose(mem_we_n) |-> mem_we_n[*2];
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulses merged");

  property p_row_fixed;
    !mem_ce_n && $past(!mem_ce_n) |->
      mem_addr[`APM_ADDR_W-1:`APM_COL_W] == $past(mem_addr[`APM_ADDR_W-1:`APM_COL_W]);
  endproperty
  a_row_fixed: assert property (p_row_fixed) else $error("row changed while open");

  property p_no_fight;
    !dq_oe_n |-> mem_oe_n;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus driven with gate low");

  property p_read_time;
    rsp_valid |-> $past(!mem_oe_n) && $past(ce_lo_cnt) >= `APM_PAGE_CYC;
  endproperty
  a_read_time: assert property (p_read_time) else $error("read sampled early");

  property p_sleep_quiet;
    $fell(sleep_request_n) |-> $past(mem_ce_n) && $past(mem_we_n) && dq_oe_n;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep during access");

  property p_wake;
    $fell(mem_ce_n) |-> $past(awake_cnt) >= `APM_WAKE_CYC;
  endproperty
  a_wake: assert property (p_wake) else $error("access before wake delay");

  property p_random_gap;
    $fell(mem_ce_n) |-> $past(rc_ff) == '0;
  endproperty
  a_random_gap: assert property (p_random_gap) else $error("random cycle too short");
endmodule

//--- tb/apm_mem_model.sv
`include "apm_regs.svh"
module apm_mem_model
  import apm_pkg::*;
#(
  parameter int ACC_NS  = `APM_ADDR_ACCESS_NS,
  parameter int PAGE_NS = `APM_PAGE_ACCESS_NS
)(
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_ce_n,
  input  wire logic        mem_we_n,
  input  wire logic        mem_oe_n,
  input  wire logic        high_byte_sel_n,
  input  wire logic        low_byte_sel_n,
  input  wire logic        sleep_request_n,
  input  wire logic [15:0] dq,
  output      logic [15:0] rd_data,
  output      logic [1:0]  drv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:65535];
  logic [13:0] row_q = '0;
  logic        fresh = 1'b1;
  logic        wr_on = 1'b0;
  logic        ok    = 1'b0;
  time         t_ok  = 0;
  logic        rd;
  always @(posedge mem_ce_n) fresh = 1'b1;
  // new row costs the full access, a column change only the page access
  always @(negedge mem_ce_n or mem_addr) begin
    if (sleep_request_n && !mem_ce_n) begin
      t_ok = $time + ((fresh || mem_addr[15:2] != row_q) ? ACC_NS : PAGE_NS);
      row_q = mem_addr[15:2];
      fresh = 1'b0;
    end
  end
  always #1 ok = ($time >= t_ok);
  always @(negedge mem_we_n or negedge mem_ce_n) begin
    if (sleep_request_n && !mem_ce_n && !mem_we_n) wr_on = 1'b1;
  end
  always @(posedge mem_we_n or posedge mem_ce_n) begin
    if (wr_on) begin
      if (!high_byte_sel_n) mem[mem_addr][15:8] = dq[15:8];
      if (!low_byte_sel_n) mem[mem_addr][7:0] = dq[7:0];
      wr_on = 1'b0;
    end
  end
  assign rd = sleep_request_n && !mem_ce_n && mem_we_n && !mem_oe_n && ok;
  assign drv = {2{rd}} & ~{high_byte_sel_n, low_byte_sel_n};
  assign rd_data = mem[mem_addr];
endmodule

//--- tb/tb.sv
`include "apm_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import apm_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, sleep_req = 1'b0;
  logic req_ready, rsp_valid, mem_ce_n, mem_we_n, mem_oe_n, dq_oe_n;
  logic high_byte_sel_n, low_byte_sel_n, sleep_request_n;
  apm_req_t req = '0;
  logic [15:0] rsp_data, mem_addr, dq_out, dq_in, rd_data, flt = 16'h5A5A;
  logic [1:0] drv;
  logic [15:0] rq[$];
  int n_fail = 0, checked = 0, cyc = 0, t_take = 0, t_rsp = 0, n;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    flt <= ~flt;
    if (rsp_valid === 1'b1) begin
      rq.push_back(rsp_data);
      t_rsp = cyc;
    end
  end
  // undriven bytes toggle so a stale value never reads back as a match
  assign dq_in[15:8] = !dq_oe_n ? dq_out[15:8] : drv[1] ? rd_data[15:8] : flt[15:8];
  assign dq_in[7:0] = !dq_oe_n ? dq_out[7:0] : drv[0] ? rd_data[7:0] : flt[7:0];
  apm_host i_apm_host (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .sleep_req(sleep_req), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
    .mem_oe_n(mem_oe_n), .high_byte_sel_n(high_byte_sel_n), .low_byte_sel_n(low_byte_sel_n),
    .sleep_request_n(sleep_request_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  apm_mem_model i_apm_mem_model (.mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .high_byte_sel_n(high_byte_sel_n),
    .low_byte_sel_n(low_byte_sel_n), .sleep_request_n(sleep_request_n), .dq(dq_in),
    .rd_data(rd_data), .drv(drv));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] be);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d, be_n: be};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    t_take = cyc;
    if (n >= 200) chk(16'h0, 16'h1);
  endtask
  task automatic idle;
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask
  task automatic drain(input int k);
    n = 0;
    while (rq.size() < k && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(rq.size()), 16'(k));
  endtask
  task automatic t_rand;
    put(1'b1, 16'h0105, 16'h1234, 2'h0);
    put(1'b1, 16'h4105, 16'h5678, 2'h0);
    idle;
    // let the row close so the read starts with a fresh chip-select fall
    repeat (8) @(posedge sys_clk);
    put(1'b0, 16'h0105, 16'h0000, 2'h0);
    idle;
    drain(1);
    chk(rq.pop_front(), 16'h1234);
    chk(16'(t_rsp - t_take), 16'(`APM_ACC_CYC + 2));
    $display("test rand done");
  endtask
  task automatic t_page;
    for (int i = 0; i < 4; i++) put(1'b1, 16'h2200 + 16'(i), 16'hC0D0 + 16'(i), 2'h0);
    idle;
    for (int i = 0; i < 4; i++) put(1'b0, 16'h2203 - 16'(i), 16'h0000, 2'h0);
    idle;
    drain(4);
    for (int i = 0; i < 4; i++) chk(rq.pop_front(), 16'hC0D3 - 16'(i));
    chk(16'(t_rsp - t_take), 16'(`APM_PAGE_CYC + 2));
    $display("test page done");
  endtask
  task automatic t_byte;
    put(1'b1, 16'h7FFF, 16'h1234, 2'h0);
    put(1'b1, 16'h7FFF, 16'hABCD, 2'h2);
    put(1'b1, 16'h7FFF, 16'hEF55, 2'h1);
    idle;
    put(1'b0, 16'h7FFF, 16'h0000, 2'h0);
    idle;
    drain(1);
    chk(rq.pop_front(), 16'hEFCD);
    $display("test byte done");
  endtask
  task automatic t_sleep;
    @(negedge sys_clk);
    sleep_req = 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(16'(sleep_request_n), 16'h0);
    chk(16'(req_ready), 16'h0);
    @(negedge sys_clk);
    sleep_req = 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    chk(16'(n >= `APM_WAKE_CYC && n < 200), 16'h1);
    put(1'b0, 16'h7FFF, 16'h0000, 2'h0);
    idle;
    drain(1);
    chk(rq.pop_front(), 16'hEFCD);
    $display("test sleep done");
  endtask
  task automatic conclude;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    t_rand;
    t_page;
    t_byte;
    t_sleep;
    conclude;
  end
endmodule
